// >>> common/slmt_consts.vh
// Constants for the security life-cycle mode tracker
`ifndef SLMT_CONSTS_VH
`define SLMT_CONSTS_VH

// ----------------------------------------------------------------
// Command opcodes on the command port
// ----------------------------------------------------------------
`define SLMT_OP_IDENTIFY 4'h0
`define SLMT_OP_SEC_SET_PW 4'h1
`define SLMT_OP_SEC_UNLOCK 4'h2
`define SLMT_OP_SEC_ERASE_UNIT 4'h3
`define SLMT_OP_SEC_DISABLE_PW 4'h4
`define SLMT_OP_SEC_FREEZE 4'h5
`define SLMT_OP_TRUSTED_SEND 4'h6
`define SLMT_OP_TRUSTED_RECV 4'h7
`define SLMT_OP_TCG_LSP_ACCESS 4'h8
`define SLMT_OP_TCG_PERSONALIZE 4'h9
`define SLMT_OP_TCG_AUTH_SID 4'hA
`define SLMT_OP_TCG_ACTIVATE 4'hB
`define SLMT_OP_TCG_REVERT 4'hC

// ----------------------------------------------------------------
// Life-cycle modes
// ----------------------------------------------------------------
`define SLMT_MODE_FACTORY 2'h0
`define SLMT_MODE_PASSWORD 2'h1
`define SLMT_MODE_TCG 2'h2

// ----------------------------------------------------------------
// Block SID command match values and discovery feature code
// ----------------------------------------------------------------
`define SLMT_BSID_PROTO 8'h02
`define SLMT_BSID_COMID 16'h0005
`define SLMT_BSID_FEATURE_CODE 16'h0402

// ----------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------
`define SLMT_REG_STATUS 4'h0
`define SLMT_REG_IDENT 4'h4
`define SLMT_REG_CTRL 4'h8
`define SLMT_REG_ABORTS 4'hC
`define SLMT_CTRL_RESET 2'h1
`define SLMT_CTRL_BSID_EN_BIT 0
`define SLMT_CTRL_FORCE_RESTRICT_BIT 1

// ----------------------------------------------------------------
// Identify word field positions
// ----------------------------------------------------------------
`define SLMT_ID_SUPPORTED_BIT 0
`define SLMT_ID_ENABLED_BIT 1
`define SLMT_ID_LOCKED_BIT 2
`define SLMT_ID_FROZEN_BIT 3
`define SLMT_ID_TCG_READY_BIT 4
`define SLMT_ID_TCG_ACTIVE_BIT 5
`define SLMT_ID_TCG_MODE_BIT 6

`endif

// >>> design/slmt_gate.v
// Per-command accept or abort decision for the mode tracker
`include "slmt_consts.vh"

module slmt_gate (
    op,
    pw_enabled,
    pw_locked,
    pw_frozen,
    tcg_pers,
    tcg_active,
    block_sid,
    bsid_feat_en,
    auth_ok,
    proto,
    comid,
    xfer_len,
    byte0,
    abort,
    effect,
    bsid_cmd
);
    input wire [3:0] op;
    input wire pw_enabled;
    input wire pw_locked;
    input wire pw_frozen;
    input wire tcg_pers;
    input wire tcg_active;
    input wire block_sid;
    input wire bsid_feat_en;
    input wire auth_ok;
    input wire [7:0] proto;
    input wire [15:0] comid;
    input wire [15:0] xfer_len;
    input wire [7:0] byte0;
    output reg abort;
    output reg effect;
    output wire bsid_cmd;

    wire pw_pers;
    wire pw_blocked;

    // Password scheme personalized: enabled or locked
    assign pw_pers = pw_enabled | pw_locked;
    assign pw_blocked = tcg_pers | tcg_active;
    assign bsid_cmd = (proto == `SLMT_BSID_PROTO) && (comid == `SLMT_BSID_COMID)
                      && (xfer_len != 16'h0000);

    // Decision table; effect means the state change is carried out
    always @* begin
        abort = 1'b0;
        effect = 1'b0;
        case (op)
            `SLMT_OP_IDENTIFY: begin
                effect = 1'b1;
            end
            `SLMT_OP_SEC_SET_PW: begin
                abort = pw_blocked | pw_frozen | pw_locked;
                effect = ~abort;
            end
            `SLMT_OP_SEC_UNLOCK: begin
                abort = pw_blocked | ~pw_enabled | ~auth_ok;
                effect = ~abort;
            end
            `SLMT_OP_SEC_ERASE_UNIT: begin
                abort = pw_blocked | pw_frozen | ~auth_ok;
                effect = ~abort;
            end
            `SLMT_OP_SEC_DISABLE_PW: begin
                abort = pw_blocked | pw_frozen | pw_locked | ~pw_enabled | ~auth_ok;
                effect = ~abort;
            end
            `SLMT_OP_SEC_FREEZE: begin
                abort = pw_blocked;
                effect = ~abort;
            end
            `SLMT_OP_TRUSTED_RECV: begin
                abort = pw_locked;
                effect = ~abort;
            end
            `SLMT_OP_TRUSTED_SEND: begin
                if (pw_locked) begin
                    abort = 1'b1;
                end else if (bsid_cmd) begin
                    abort = ~bsid_feat_en | (byte0 > 8'h01);
                    effect = ~abort;
                end else begin
                    effect = 1'b1;
                end
            end
            `SLMT_OP_TCG_LSP_ACCESS, `SLMT_OP_TCG_PERSONALIZE: begin
                abort = pw_pers | ~auth_ok;
                effect = ~abort;
            end
            `SLMT_OP_TCG_AUTH_SID: begin
                abort = block_sid | ~auth_ok;
                effect = ~abort;
            end
            `SLMT_OP_TCG_ACTIVATE: begin
                if (pw_locked) begin
                    abort = 1'b1;
                end else if (pw_enabled | tcg_active) begin
                    effect = 1'b0;
                end else begin
                    abort = ~auth_ok;
                    effect = auth_ok;
                end
            end
            `SLMT_OP_TCG_REVERT: begin
                if (pw_locked) begin
                    abort = 1'b1;
                end else if (~tcg_active) begin
                    effect = 1'b0;
                end else begin
                    abort = ~auth_ok;
                    effect = auth_ok;
                end
            end
            default: begin
                abort = 1'b1;
            end
        endcase
    end
endmodule // slmt_gate

// >>> design/slmt_tracker.v
// Security life-cycle mode tracker: mode state, Block SID latch, registers
`include "slmt_consts.vh"

module slmt_tracker #(
    parameter ABORT_CNT_W = 16
) (
    clock,
    rst,
    hw_reset_pin,
    cmd_valid,
    cmd_op,
    cmd_auth_ok,
    cmd_proto,
    cmd_comid,
    cmd_xfer_len,
    cmd_byte0,
    cmd_done,
    cmd_abort,
    data_discard,
    ident_word,
    life_mode,
    enforce_restrict,
    tcg_advertised,
    disc_bsid_present,
    disc_feature_code,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata
);
    input wire clock;
    input wire rst;
    input wire hw_reset_pin;
    input wire cmd_valid;
    input wire [3:0] cmd_op;
    input wire cmd_auth_ok;
    input wire [7:0] cmd_proto;
    input wire [15:0] cmd_comid;
    input wire [15:0] cmd_xfer_len;
    input wire [7:0] cmd_byte0;
    output reg cmd_done;
    output reg cmd_abort;
    output reg data_discard;
    output reg [15:0] ident_word;
    output reg [1:0] life_mode;
    output reg enforce_restrict;
    output wire tcg_advertised;
    output reg disc_bsid_present;
    output wire [15:0] disc_feature_code;
    input wire [3:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [31:0] reg_rdata;

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    reg [1:0] mode_q;
    reg [1:0] mode_d;
    reg pw_enabled_q;
    reg pw_enabled_d;
    reg pw_locked_q;
    reg pw_locked_d;
    reg pw_frozen_q;
    reg pw_frozen_d;
    reg tcg_pers_q;
    reg tcg_pers_d;
    reg tcg_active_q;
    reg tcg_active_d;
    reg block_sid_q;
    reg block_sid_d;
    reg clr_events_q;
    reg clr_events_d;
    reg [1:0] ctrl_q;
    reg [ABORT_CNT_W-1:0] abort_cnt_q;
    reg hwr_sync1_q;
    reg hwr_sync2_q;
    reg hwr_prev_q;
    wire hwr_event;
    wire gate_abort;
    wire gate_effect;
    wire gate_bsid;
    reg [15:0] ident_d;

    // ----------------------------------------------------------------
    // Hardware reset pin synchroniser and rising-edge detect
    // ----------------------------------------------------------------
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            hwr_sync1_q <= 1'b0;
            hwr_sync2_q <= 1'b0;
            hwr_prev_q <= 1'b0;
        end else begin
            hwr_sync1_q <= hw_reset_pin;
            hwr_sync2_q <= hwr_sync1_q;
            hwr_prev_q <= hwr_sync2_q;
        end
    end

    assign hwr_event = hwr_sync2_q & ~hwr_prev_q;

    // ----------------------------------------------------------------
    // Command decision
    // ----------------------------------------------------------------
    // check against state
    slmt_gate u_gate (
        .op(cmd_op),
        .pw_enabled(pw_enabled_q),
        .pw_locked(pw_locked_q),
        .pw_frozen(pw_frozen_q),
        .tcg_pers(tcg_pers_q),
        .tcg_active(tcg_active_q),
        .block_sid(block_sid_q),
        .bsid_feat_en(ctrl_q[`SLMT_CTRL_BSID_EN_BIT]),
        .auth_ok(cmd_auth_ok),
        .proto(cmd_proto),
        .comid(cmd_comid),
        .xfer_len(cmd_xfer_len),
        .byte0(cmd_byte0),
        .abort(gate_abort),
        .effect(gate_effect),
        .bsid_cmd(gate_bsid)
    );

    // ----------------------------------------------------------------
    // Next-state logic for mode and flags
    // ----------------------------------------------------------------
    // Commands apply first; a hardware reset in the same cycle then overrides
    always @* begin
        mode_d = mode_q;
        pw_enabled_d = pw_enabled_q;
        pw_locked_d = pw_locked_q;
        pw_frozen_d = pw_frozen_q;
        tcg_pers_d = tcg_pers_q;
        tcg_active_d = tcg_active_q;
        block_sid_d = block_sid_q;
        clr_events_d = clr_events_q;
        if (cmd_valid && gate_effect) begin
            case (cmd_op)
                `SLMT_OP_SEC_SET_PW: begin
                    pw_enabled_d = 1'b1;
                    mode_d = `SLMT_MODE_PASSWORD;
                end
                `SLMT_OP_SEC_UNLOCK: begin
                    pw_locked_d = 1'b0;
                end
                `SLMT_OP_SEC_ERASE_UNIT, `SLMT_OP_SEC_DISABLE_PW: begin
                    pw_enabled_d = 1'b0;
                    pw_locked_d = 1'b0;
                    mode_d = `SLMT_MODE_FACTORY;
                end
                `SLMT_OP_SEC_FREEZE: begin
                    pw_frozen_d = 1'b1;
                end
                `SLMT_OP_TRUSTED_SEND: begin
                    if (gate_bsid) begin
                        block_sid_d = 1'b1;
                        clr_events_d = cmd_byte0[0];
                    end
                end
                `SLMT_OP_TCG_LSP_ACCESS: begin
                    mode_d = `SLMT_MODE_TCG;
                end
                `SLMT_OP_TCG_PERSONALIZE: begin
                    mode_d = `SLMT_MODE_TCG;
                    tcg_pers_d = 1'b1;
                end
                `SLMT_OP_TCG_ACTIVATE: begin
                    mode_d = `SLMT_MODE_TCG;
                    tcg_active_d = 1'b1;
                end
                `SLMT_OP_TCG_REVERT: begin
                    mode_d = `SLMT_MODE_FACTORY;
                    tcg_pers_d = 1'b0;
                    tcg_active_d = 1'b0;
                    block_sid_d = 1'b0;
                    clr_events_d = 1'b0;
                end
                default: begin
                    mode_d = mode_q;
                end
            endcase
        end
        if (hwr_event) begin
            // Password set locks the device again across a hardware reset
            pw_locked_d = pw_enabled_d;
            pw_frozen_d = 1'b0;
            if (clr_events_d) begin
                block_sid_d = 1'b0;
                clr_events_d = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // State flip-flops
    // ----------------------------------------------------------------
    // factory state at power-on
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= `SLMT_MODE_FACTORY;
            pw_enabled_q <= 1'b0;
            pw_locked_q <= 1'b0;
            pw_frozen_q <= 1'b0;
            tcg_pers_q <= 1'b0;
            tcg_active_q <= 1'b0;
            block_sid_q <= 1'b0;
            clr_events_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            pw_enabled_q <= pw_enabled_d;
            pw_locked_q <= pw_locked_d;
            pw_frozen_q <= pw_frozen_d;
            tcg_pers_q <= tcg_pers_d;
            tcg_active_q <= tcg_active_d;
            block_sid_q <= block_sid_d;
            clr_events_q <= clr_events_d;
        end
    end

    // ----------------------------------------------------------------
    // Command completion and reporting outputs
    // ----------------------------------------------------------------
    // identify reporting
    always @* begin
        ident_d = 16'h0000;
        ident_d[`SLMT_ID_SUPPORTED_BIT] = ~tcg_active_d;
        ident_d[`SLMT_ID_ENABLED_BIT] = pw_enabled_d & ~tcg_active_d;
        ident_d[`SLMT_ID_LOCKED_BIT] = pw_locked_d & ~tcg_active_d;
        ident_d[`SLMT_ID_FROZEN_BIT] = pw_frozen_d & ~tcg_active_d;
        ident_d[`SLMT_ID_TCG_READY_BIT] = 1'b1;
        ident_d[`SLMT_ID_TCG_ACTIVE_BIT] = tcg_active_d;
        ident_d[`SLMT_ID_TCG_MODE_BIT] = (mode_d == `SLMT_MODE_TCG);
    end

    // Done and abort pulse one cycle after the command
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_done <= 1'b0;
            cmd_abort <= 1'b0;
            data_discard <= 1'b0;
            ident_word <= 16'h0000;
            life_mode <= `SLMT_MODE_FACTORY;
            enforce_restrict <= 1'b0;
            disc_bsid_present <= 1'b0;
            abort_cnt_q <= {ABORT_CNT_W{1'b0}};
        end else begin
            cmd_done <= cmd_valid & ~gate_abort;
            cmd_abort <= cmd_valid & gate_abort;
            data_discard <= cmd_valid & gate_effect & (cmd_op == `SLMT_OP_TCG_REVERT);
            ident_word <= ident_d;
            life_mode <= mode_d;
            enforce_restrict <= (mode_d == `SLMT_MODE_TCG)
                                | ctrl_q[`SLMT_CTRL_FORCE_RESTRICT_BIT];
            disc_bsid_present <= ctrl_q[`SLMT_CTRL_BSID_EN_BIT];
            if (cmd_valid && gate_abort) begin
                abort_cnt_q <= abort_cnt_q + {{(ABORT_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign tcg_advertised = 1'b1;
    assign disc_feature_code = `SLMT_BSID_FEATURE_CODE;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    // Control register write
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_q <= `SLMT_CTRL_RESET;
        end else if (reg_wr && (reg_addr == `SLMT_REG_CTRL)) begin
            ctrl_q <= reg_wdata[1:0];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `SLMT_REG_STATUS: reg_rdata <= {24'h000000, clr_events_q, block_sid_q,
                    tcg_active_q, tcg_pers_q, pw_frozen_q, pw_locked_q, mode_q};
                `SLMT_REG_IDENT: reg_rdata <= {16'h0000, ident_word};
                `SLMT_REG_CTRL: reg_rdata <= {30'h00000000, ctrl_q};
                `SLMT_REG_ABORTS: reg_rdata <= {{(32-ABORT_CNT_W){1'b0}}, abort_cnt_q};
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // slmt_tracker

// >>> verification/slmt_host.sv
// Host model issuing security commands on the command port
`include "slmt_consts.vh"

module slmt_host (
    input wire clock,
    output logic cmd_valid,
    output logic [3:0] cmd_op,
    output logic cmd_auth_ok,
    output logic [7:0] cmd_proto,
    output logic [15:0] cmd_comid,
    output logic [15:0] cmd_xfer_len,
    output logic [7:0] cmd_byte0,
    input wire cmd_done,
    input wire cmd_abort,
    input wire data_discard
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port at time zero
    initial begin
        cmd_valid = 1'b0;
        {cmd_op, cmd_auth_ok, cmd_proto, cmd_comid, cmd_xfer_len, cmd_byte0} = '0;
    end
    // One command, answer taken one cycle after it is driven
    task automatic issue(input logic [3:0] op, input logic auth, input logic [7:0] pr,
        input logic [15:0] ci, input logic [15:0] ln, input logic [7:0] b0,
        output logic d, output logic a, output logic x);
        @(posedge clock);
        cmd_valid <= 1'b1;
        {cmd_op, cmd_auth_ok, cmd_proto, cmd_comid, cmd_xfer_len, cmd_byte0} <=
            {op, auth, pr, ci, ln, b0};
        @(posedge clock);
        cmd_valid <= 1'b0;
        // Released fields flip so stale values are never mistaken for live ones
        {cmd_op, cmd_auth_ok, cmd_proto, cmd_comid, cmd_xfer_len, cmd_byte0} <=
            ~{op, auth, pr, ci, ln, b0};
        #1;
        d = cmd_done;
        a = cmd_abort;
        x = data_discard;
    endtask
    // Block SID framing; only the first payload byte is driven
    task automatic block_sid(input logic [7:0] b0, output logic d, output logic a);
        logic x;
        issue(`SLMT_OP_TRUSTED_SEND, 1'b1, `SLMT_BSID_PROTO, `SLMT_BSID_COMID, 16'h0200,
            b0, d, a, x);
    endtask
endmodule // slmt_host

// >>> verification/slmt_tracker_chk.sv
// Port checker for the security life-cycle mode tracker
`include "slmt_consts.vh"

module slmt_tracker_chk (
    input wire clock,
    input wire rst,
    input wire cmd_valid,
    input wire [3:0] cmd_op,
    input wire cmd_done,
    input wire cmd_abort,
    input wire data_discard,
    input wire [15:0] ident_word,
    input wire [1:0] life_mode,
    input wire enforce_restrict,
    input wire tcg_advertised,
    input wire [15:0] disc_feature_code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Command answers and mode
    // ------------------------------------------------------------
    // single answer
    a_answer_once: assert property (cmd_valid |=> cmd_done ^ cmd_abort)
        else $error("command not answered exactly once");
    a_discard_revert: assert property (data_discard |-> cmd_done &&
        life_mode == `SLMT_MODE_FACTORY && $past(cmd_op) == `SLMT_OP_TCG_REVERT)
        else $error("discard without revert to factory");
    a_restrict_tcg: assert property (life_mode == `SLMT_MODE_TCG &&
        $stable(life_mode) |-> enforce_restrict)
        else $error("restrictions off in TCG mode");
    a_ident_hidden: assert property (ident_word[5] |-> ident_word[3:0] == 4'h0)
        else $error("password status shown while activated");
    a_tcg_ready: assert property (!$past(rst) |-> ident_word[4] && tcg_advertised)
        else $error("TCG not advertised");
    a_pw_blocks_lsp: assert property (cmd_valid && cmd_op == `SLMT_OP_TCG_LSP_ACCESS &&
        ident_word[1] |=> cmd_abort)
        else $error("locking space open with password set");
    a_act_refused: assert property (cmd_valid && cmd_op == `SLMT_OP_TCG_ACTIVATE &&
        ident_word[1] |=> !ident_word[5])
        else $error("activated with password set");
    a_lsp_to_tcg: assert property (cmd_valid && cmd_op == `SLMT_OP_TCG_LSP_ACCESS ##1
        cmd_done |-> life_mode == `SLMT_MODE_TCG)
        else $error("accepted locking access left mode");
    a_trusted_locked: assert property (cmd_valid && ident_word[2] &&
        (cmd_op == `SLMT_OP_TRUSTED_SEND || cmd_op == `SLMT_OP_TRUSTED_RECV) |=> cmd_abort)
        else $error("trusted command taken while locked");
    a_code_fixed: assert property (disc_feature_code == `SLMT_BSID_FEATURE_CODE)
        else $error("wrong discovery feature code");
    c_revert: cover property (data_discard);
    c_sid_block: cover property (cmd_valid && cmd_op == `SLMT_OP_TCG_AUTH_SID ##1 cmd_abort);
    c_lsp: cover property (cmd_valid && cmd_op == `SLMT_OP_TCG_LSP_ACCESS ##1 cmd_done);
endmodule // slmt_tracker_chk

// >>> verification/slmt_tracker_tb_top.sv
// Self-checking bench for the security life-cycle mode tracker
`include "slmt_consts.vh"

module slmt_tracker_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hw_reset_pin = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire cmd_valid, cmd_auth_ok, cmd_done, cmd_abort, data_discard;
    wire enforce_restrict, tcg_advertised, disc_bsid_present;
    wire [3:0] cmd_op;
    wire [7:0] cmd_proto, cmd_byte0;
    wire [15:0] cmd_comid, cmd_xfer_len, ident_word, disc_feature_code;
    wire [1:0] life_mode;
    wire [31:0] reg_rdata;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 93;
    int n_abort_exp = 0;
    logic r_d, r_a, r_x;
    always #10 clock = ~clock;
    slmt_tracker dut (.clock(clock), .rst(rst), .hw_reset_pin(hw_reset_pin),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_auth_ok(cmd_auth_ok),
        .cmd_proto(cmd_proto), .cmd_comid(cmd_comid), .cmd_xfer_len(cmd_xfer_len),
        .cmd_byte0(cmd_byte0), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
        .data_discard(data_discard), .ident_word(ident_word), .life_mode(life_mode),
        .enforce_restrict(enforce_restrict), .tcg_advertised(tcg_advertised),
        .disc_bsid_present(disc_bsid_present), .disc_feature_code(disc_feature_code),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    slmt_host u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_auth_ok(cmd_auth_ok), .cmd_proto(cmd_proto), .cmd_comid(cmd_comid),
        .cmd_xfer_len(cmd_xfer_len), .cmd_byte0(cmd_byte0), .cmd_done(cmd_done),
        .cmd_abort(cmd_abort), .data_discard(data_discard));
    // ------------------------------------------------------------
    // Compare, report and expectation helpers
    // ------------------------------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Identify word: password bits hidden while activated
    function automatic logic [31:0] idw(logic en, logic lk, logic act, logic tm);
        return {25'h0, tm, act, 1'b1, 1'b0, lk & ~act, en & ~act, ~act};
    endfunction
    task automatic cmd(input logic [3:0] op, input logic auth, input logic exp_d);
        u_host.issue(op, auth, 8'h00, 16'h0000, 16'h0001, 8'h00, r_d, r_a, r_x);
        chk_word({r_d, r_a}, {exp_d, ~exp_d});
        n_abort_exp += !exp_d;
    endtask
    task automatic bsid(input logic [7:0] b0, input logic exp_d);
        u_host.block_sid(b0, r_d, r_a);
        chk_word({r_d, r_a}, {exp_d, ~exp_d});
        n_abort_exp += !exp_d;
    endtask
    // Levels are compared one cycle later so either update timing is covered
    task automatic state(input logic [1:0] m, input logic [31:0] id, input logic rs);
        @(posedge clock);
        #1;
        chk_word({life_mode, enforce_restrict, ident_word}, {m, rs, id[15:0]});
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk_word(reg_rdata, exp);
    endtask
    task automatic hw_rst();
        @(posedge clock);
        hw_reset_pin <= 1'b1;
        repeat (2) @(posedge clock);
        hw_reset_pin <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        state(`SLMT_MODE_FACTORY, idw(0, 0, 0, 0), 1'b0);
        reg_write(`SLMT_REG_STATUS, 32'hFF);
        reg_read(`SLMT_REG_STATUS, 32'h0);
        reg_read(`SLMT_REG_CTRL, {30'h0, `SLMT_CTRL_RESET});
        reg_read(4'h2, 32'h0);
        chk_word({tcg_advertised, disc_bsid_present, disc_feature_code},
            {2'b11, `SLMT_BSID_FEATURE_CODE});
        cmd(`SLMT_OP_SEC_SET_PW, 1, 1);
        cmd(`SLMT_OP_TCG_LSP_ACCESS, 1, 0);
        cmd(`SLMT_OP_TCG_ACTIVATE, 1, 1);
        state(`SLMT_MODE_PASSWORD, idw(1, 0, 0, 0), 1'b0);
        hw_rst();
        reg_read(`SLMT_REG_IDENT, idw(1, 1, 0, 0));
        cmd(`SLMT_OP_TRUSTED_SEND, 1, 0);
        cmd(`SLMT_OP_TRUSTED_RECV, 1, 0);
        cmd(`SLMT_OP_IDENTIFY, 0, 1);
        cmd(`SLMT_OP_TCG_ACTIVATE, 1, 0);
        cmd(`SLMT_OP_SEC_UNLOCK, 0, 0);
        cmd(`SLMT_OP_SEC_UNLOCK, 1, 1);
        cmd(`SLMT_OP_SEC_DISABLE_PW, 1, 1);
        state(`SLMT_MODE_FACTORY, idw(0, 0, 0, 0), 1'b0);
        cmd(`SLMT_OP_SEC_SET_PW, 1, 1);
        cmd(`SLMT_OP_SEC_ERASE_UNIT, 1, 1);
        state(`SLMT_MODE_FACTORY, idw(0, 0, 0, 0), 1'b0);
        u_host.issue(`SLMT_OP_TCG_REVERT, 1, 0, 0, 1, 0, r_d, r_a, r_x);
        chk_word({r_d, r_x}, 2'b10);
        cmd(`SLMT_OP_TCG_LSP_ACCESS, 1, 1);
        state(`SLMT_MODE_TCG, idw(0, 0, 0, 1), 1'b1);
        cmd(`SLMT_OP_TCG_PERSONALIZE, 1, 1);
        cmd(`SLMT_OP_SEC_SET_PW, 1, 0);
        cmd(`SLMT_OP_TCG_ACTIVATE, 1, 1);
        state(`SLMT_MODE_TCG, idw(0, 0, 1, 1), 1'b1);
        cmd(`SLMT_OP_SEC_FREEZE, 1, 0);
        cmd(`SLMT_OP_TCG_AUTH_SID, 1, 1);
        bsid(8'h01, 1);
        cmd(`SLMT_OP_TCG_AUTH_SID, 1, 0);
        reg_read(`SLMT_REG_STATUS, 32'hF2);
        hw_rst();
        cmd(`SLMT_OP_TCG_AUTH_SID, 1, 1);
        bsid(8'h00, 1);
        hw_rst();
        cmd(`SLMT_OP_TCG_AUTH_SID, 1, 0);
        bsid(8'h02, 0);
        u_host.issue(`SLMT_OP_TCG_REVERT, 1, 0, 0, 1, 0, r_d, r_a, r_x);
        chk_word({r_d, r_x}, 2'b11);
        state(`SLMT_MODE_FACTORY, idw(0, 0, 0, 0), 1'b0);
        cmd(`SLMT_OP_TCG_AUTH_SID, 1, 1);
        reg_write(`SLMT_REG_CTRL, 32'h0);
        bsid(8'h00, 0);
        chk_word(disc_bsid_present, 1'b0);
        reg_write(`SLMT_REG_CTRL, 32'h3);
        bsid(8'h00, 1);
        state(`SLMT_MODE_FACTORY, idw(0, 0, 0, 0), 1'b1);
        reg_read(`SLMT_REG_ABORTS, n_abort_exp);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        state(`SLMT_MODE_FACTORY, idw(0, 0, 0, 0), 1'b0);
        cmd(`SLMT_OP_TCG_AUTH_SID, 1, 1);
        // Random command traffic, each must get exactly one answer
        repeat (60) begin
            u_host.issue($random(seed), $random(seed), `SLMT_BSID_PROTO,
                `SLMT_BSID_COMID, $random(seed), $random(seed) & 8'h03, r_d, r_a, r_x);
            chk_word(r_d ^ r_a, 1'b1);
        end
        conclude();
    end
endmodule // slmt_tracker_tb_top

bind slmt_tracker slmt_tracker_chk u_chk (.clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_done(cmd_done), .cmd_abort(cmd_abort),
    .data_discard(data_discard), .ident_word(ident_word), .life_mode(life_mode),
    .enforce_restrict(enforce_restrict), .tcg_advertised(tcg_advertised),
    .disc_feature_code(disc_feature_code));
